// >>> verilog/odc_regs.sv
// Contract
// - monitor selector bits D15..D4 are one-hot; all zero leaves monitor pin hi-z.
// - invalid selector value is stored, but monitor pin forced to hi-z.
// - D4 ref B, D5 ref A, D6 offset B, D7 offset A, D8..D15 channels 0..7.
// - monitor selector resets to zero, monitor disabled.
// - don't-care bits ignore writes and read zero.
// - input codes reset to zero; with correction off writes go straight to data.
// - channel data only reaches the output on an external latch load.
// - zero offset is 16-bit two's complement, one LSB per step.
// - zero offsets reset to zero.
// - gain is straight binary: 0 gives 0.5, 8000h gives 1, step 1/65536.
// - gains reset to 8000h, unity.
// - aux pin bit one releases the pin, zero drives it low.
// - reading aux pin bit returns the sampled pin level.
// - aux pin bit resets to one, pin released.
// - busy flags read-only, reset zero, channels 7..0 on bits D15..D8.
// - with correction on, writing code, offset or gain sets the channel's busy.
// - busy clears once the corrected code reaches the channel data register.
// - one channel takes about 500 ns; pending channels go one after another.
// - all busy flags read zero while correction is off.
// - correction enable resets off and switches the engine.
// - engine corrects with channel gain and offset into the data register.
`include "odc_cfg.svh"

module odc_regs #(
  parameter int CHANNELS = 8,
  parameter int CORR_CYCLES = `ODC_CORR_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // parallel register port
  input wire logic i_bus_cs,
  input wire logic i_bus_we,
  input wire logic i_bus_re,
  input wire logic [4:0] i_bus_addr,
  input wire logic [15:0] i_bus_wdata,
  output logic [15:0] o_bus_rdata,
  output logic o_bus_rvalid,
  // correction enable from the configuration register
  input wire logic i_correction_enable,
  // channel data registers toward the output latches
  output logic [8*16-1:0] o_channel_code_bits,
  output logic [7:0] o_channel_updated,
  // analog monitor mux
  output logic [11:0] o_analog_monitor_sel,
  output logic o_analog_monitor_oe_n,
  // open-drain aux pin
  input wire logic i_aux_pin,
  output logic o_aux_pin,
  output logic o_aux_pin_oe_n
);
  if (CHANNELS != 8) begin : g_bad_channels
    $error("odc_regs: only eight channels are supported");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic in_bank(input logic [4:0] addr, input logic [1:0] bank);
    in_bank = (addr[4:3] == bank);
  endfunction

  logic wr;
  logic rd;
  logic wr_code;
  logic wr_zero;
  logic wr_gain;
  odc_pkg::odc_chan_t wr_chan;
  assign wr = i_bus_cs && i_bus_we;
  assign rd = i_bus_cs && i_bus_re && !i_bus_we;
  assign wr_chan = i_bus_addr[2:0];
  assign wr_code = wr && in_bank(i_bus_addr, `ODC_BANK_CODE);
  assign wr_zero = wr && in_bank(i_bus_addr, `ODC_BANK_ZERO);
  assign wr_gain = wr && in_bank(i_bus_addr, `ODC_BANK_GAIN);

  // ----------------------------------------------------------------
  // monitor selector
  // ----------------------------------------------------------------
  logic [15:0] monitor_reg;
  logic [11:0] mon_route_reg;
  logic mon_oe_n_reg;
  logic [11:0] mon_wr_sel;
  assign mon_wr_sel = i_bus_wdata[`ODC_MON_MSB:`ODC_MON_LSB];

  // stores any value; only a single set bit routes the mux
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      monitor_reg <= `ODC_RST_MONITOR;
      mon_route_reg <= 12'h000;
      mon_oe_n_reg <= 1'b1;
    end else if (wr && i_bus_addr == `ODC_OFS_MONITOR) begin
      monitor_reg <= {mon_wr_sel, 4'h0};
      // bit k routes source k: refs, offsets, then channel n on bit 4+n
      mon_route_reg <= $onehot(mon_wr_sel) ? mon_wr_sel : 12'h000;
      mon_oe_n_reg <= !$onehot(mon_wr_sel);
    end
  end
  assign o_analog_monitor_sel = mon_route_reg;
  assign o_analog_monitor_oe_n = mon_oe_n_reg;

  // ----------------------------------------------------------------
  // aux pin: 3-stage sampler, level taken when stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] pin_sync_reg;
  logic pin_level_reg;
  logic aux_ctl_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_sync_reg <= 3'h7;
      pin_level_reg <= 1'b1;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], i_aux_pin};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  // write one releases, write zero pulls low
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_ctl_reg <= `ODC_RST_AUX_PIN;
    end else if (wr && i_bus_addr == `ODC_OFS_AUX_PIN) begin
      aux_ctl_reg <= i_bus_wdata[`ODC_AUX_PIN_BIT];
    end
  end
  assign o_aux_pin = 1'b0;
  assign o_aux_pin_oe_n = aux_ctl_reg;

  // ----------------------------------------------------------------
  // per-channel calibration storage
  // ----------------------------------------------------------------
  odc_pkg::odc_word_t code_reg [8];
  odc_pkg::odc_word_t zero_reg [8];
  odc_pkg::odc_word_t gain_reg [8];
  odc_pkg::odc_word_t data_reg [8];
  logic [7:0] updated_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 8; i++) begin
        code_reg[i] <= `ODC_RST_CODE;
        zero_reg[i] <= `ODC_RST_ZERO;
        gain_reg[i] <= `ODC_RST_GAIN;
      end
    end else begin
      if (wr_code) begin
        code_reg[wr_chan] <= i_bus_wdata;
      end
      if (wr_zero) begin
        zero_reg[wr_chan] <= i_bus_wdata;
      end
      if (wr_gain) begin
        gain_reg[wr_chan] <= i_bus_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // correction scheduling
  // ----------------------------------------------------------------
  odc_corr_if corr ();
  logic [7:0] busy_reg;
  logic [7:0] stale_reg;
  logic [7:0] busy_set;
  logic run_reg;
  odc_pkg::odc_chan_t run_chan_reg;
  odc_pkg::odc_chan_t pick;

  // lowest pending channel goes first
  always_comb begin
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (busy_reg[i]) begin
        pick = 3'(i);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      busy_set[i] = i_correction_enable && (wr_code || wr_zero || wr_gain) && wr_chan == 3'(i);
    end
  end

  assign corr.start = i_correction_enable && !run_reg && (busy_reg != 8'h00);
  assign corr.chan = pick;
  assign corr.code = code_reg[pick];
  assign corr.gain = gain_reg[pick];
  assign corr.offset = zero_reg[pick];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= 1'b0;
      run_chan_reg <= 3'h0;
    end else if (!i_correction_enable) begin
      run_reg <= 1'b0;
    end else if (corr.start) begin
      run_reg <= 1'b1;
      run_chan_reg <= pick;
    end else if (corr.done) begin
      run_reg <= 1'b0;
    end
  end

  // a write at the start of or during a pass on the same channel forces another pass
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stale_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (busy_set[i] && ((run_reg && run_chan_reg == 3'(i)) || (corr.start && pick == 3'(i)))) begin
          stale_reg[i] <= 1'b1;
        end else if (!i_correction_enable || (corr.start && pick == 3'(i))) begin
          stale_reg[i] <= 1'b0;
        end
      end
    end
  end

  // set wins over the completion clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= `ODC_RST_BUSY;
    end else if (!i_correction_enable) begin
      busy_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (busy_set[i]) begin
          busy_reg[i] <= 1'b1;
        end else if (corr.done && corr.done_chan == 3'(i) && !stale_reg[i]) begin
          busy_reg[i] <= 1'b0;
        end
      end
    end
  end

  odc_corr_engine #(
    .CORR_CYCLES(CORR_CYCLES)
  ) u_engine (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_enable(i_correction_enable),
    .corr(corr.eng)
  );

  // ----------------------------------------------------------------
  // channel data registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 8; i++) begin
        data_reg[i] <= `ODC_RST_CODE;
      end
      updated_reg <= 8'h00;
    end else begin
      updated_reg <= 8'h00;
      if (!i_correction_enable && wr_code) begin
        data_reg[wr_chan] <= i_bus_wdata;
        updated_reg[wr_chan] <= 1'b1;
      end else if (i_correction_enable && corr.done) begin
        data_reg[corr.done_chan] <= corr.result;
        updated_reg[corr.done_chan] <= 1'b1;
      end
    end
  end
  // latch load happens outside; only the data register is presented
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_channel_code_bits[i*16 +: 16] = data_reg[i];
    end
  end
  assign o_channel_updated = updated_reg;

  // ----------------------------------------------------------------
  // read port: answer one cycle after the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_rdata <= 16'h0000;
      o_bus_rvalid <= 1'b0;
    end else begin
      o_bus_rvalid <= rd;
      if (rd) begin
        if (in_bank(i_bus_addr, `ODC_BANK_CODE)) begin
          o_bus_rdata <= code_reg[wr_chan];
        end else if (in_bank(i_bus_addr, `ODC_BANK_ZERO)) begin
          o_bus_rdata <= zero_reg[wr_chan];
        end else if (in_bank(i_bus_addr, `ODC_BANK_GAIN)) begin
          o_bus_rdata <= gain_reg[wr_chan];
        end else if (i_bus_addr == `ODC_OFS_MONITOR) begin
          o_bus_rdata <= monitor_reg;
        end else if (i_bus_addr == `ODC_OFS_AUX_PIN) begin
          o_bus_rdata <= {pin_level_reg, 15'h0000};
        end else if (i_bus_addr == `ODC_OFS_BUSY) begin
          o_bus_rdata <= {busy_reg, 8'h00};
        end else begin
          o_bus_rdata <= 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mon_invalid_hiz: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr && i_bus_addr == `ODC_OFS_MONITOR && !$onehot(mon_wr_sel))
    |=> (o_analog_monitor_oe_n && o_analog_monitor_sel == 12'h000 && monitor_reg[15:4] == $past(mon_wr_sel)))
    else $error("invalid monitor code not forced to hi-z");
  a_mon_route_onehot: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_analog_monitor_oe_n |-> ($onehot(o_analog_monitor_sel) && o_analog_monitor_sel == monitor_reg[15:4]))
    else $error("monitor driven without a single selected source");
  a_low_bits_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    monitor_reg[3:0] == 4'h0 && !(o_bus_rvalid && $past(i_bus_addr) == `ODC_OFS_BUSY && o_bus_rdata[7:0] != 8'h00))
    else $error("don't-care bits not zero");
  a_bypass_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_correction_enable && wr_code) |=> (data_reg[$past(wr_chan)] == $past(i_bus_wdata) && busy_reg == 8'h00))
    else $error("bypass write did not reach the data register");
  a_aux_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr && i_bus_addr == `ODC_OFS_AUX_PIN) |=> (o_aux_pin_oe_n == $past(i_bus_wdata[15]) && !o_aux_pin))
    else $error("aux pin drive does not follow the written bit");
  a_aux_readback: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (rd && i_bus_addr == `ODC_OFS_AUX_PIN) |=> (o_bus_rdata == {$past(pin_level_reg), 15'h0000}))
    else $error("aux pin read does not show the sampled level");
  a_busy_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n || !i_correction_enable)
    (wr_gain || wr_zero || wr_code) |=> busy_reg[$past(wr_chan)])
    else $error("calibration write did not raise busy");
  a_busy_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (corr.done && busy_set == 8'h00 && !stale_reg[corr.done_chan])
    |=> (!busy_reg[$past(corr.done_chan)] && data_reg[$past(corr.done_chan)] == $past(corr.result)))
    else $error("busy not cleared with the data transfer");
  a_busy_off_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_correction_enable |=> (!i_correction_enable |-> busy_reg == 8'h00))
    else $error("busy flags set with correction off");
  a_one_at_a_time: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    corr.start |=> !corr.start [*2])
    else $error("second pass started while one was running");

  c_mon_valid: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $fell(o_analog_monitor_oe_n));
  c_two_pending: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $countones(busy_reg) > 1 && corr.done);
  c_rewrite_during_pass: cover property (@(posedge i_mclk) disable iff (!i_rst_n) stale_reg != 8'h00);
  c_aux_low: cover property (@(posedge i_mclk) disable iff (!i_rst_n) !o_aux_pin_oe_n);
endmodule

// >>> shared/odc_cfg.svh
`ifndef ODC_CFG_SVH
`define ODC_CFG_SVH
// ----------------------------------------------------------------
// register offsets on the parallel port
// ----------------------------------------------------------------
`define ODC_OFS_MONITOR 5'h00
`define ODC_OFS_AUX_PIN 5'h01
`define ODC_OFS_BUSY 5'h02
// channel banks: addr[4:3] picks the bank, addr[2:0] the channel
`define ODC_BANK_CODE 2'h1
`define ODC_BANK_ZERO 2'h2
`define ODC_BANK_GAIN 2'h3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ODC_RST_MONITOR 16'h0000
`define ODC_RST_CODE 16'h0000
`define ODC_RST_ZERO 16'h0000
`define ODC_RST_GAIN 16'h8000
`define ODC_RST_AUX_PIN 1'b1
`define ODC_RST_BUSY 8'h00
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ODC_MON_LSB 4
`define ODC_MON_MSB 15
`define ODC_AUX_PIN_BIT 15
`define ODC_BUSY_LSB 8
// gain code of 0 means a coefficient of 0.5, i.e. 8000h in 1/65536 steps
`define ODC_GAIN_BASE 17'h08000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ODC_CLK_PERIOD_NS 5
`define ODC_CORR_TIME_NS 500
`define ODC_CORR_CYCLES (`ODC_CORR_TIME_NS / `ODC_CLK_PERIOD_NS)
`endif

// >>> shared/odc_pkg.sv
package odc_pkg;
  typedef logic [15:0] odc_word_t;
  typedef logic [2:0] odc_chan_t;
  // engine states, one-hot
  typedef enum logic [1:0] {
    ODC_IDLE = 2'b01,
    ODC_RUN = 2'b10
  } odc_eng_state_e;
endpackage

// >>> shared/odc_corr_if.sv
interface odc_corr_if;
  logic start;
  odc_pkg::odc_chan_t chan;
  odc_pkg::odc_word_t code;
  odc_pkg::odc_word_t gain;
  odc_pkg::odc_word_t offset;
  logic done;
  odc_pkg::odc_chan_t done_chan;
  odc_pkg::odc_word_t result;
  modport ctrl (output start, chan, code, gain, offset, input done, done_chan, result);
  modport eng (input start, chan, code, gain, offset, output done, done_chan, result);
endinterface

// >>> verilog/odc_corr_engine.sv
`include "odc_cfg.svh"

module odc_corr_engine #(
  parameter int CORR_CYCLES = `ODC_CORR_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // engine on/off; off aborts a running correction
  input wire logic i_enable,
  // request and result
  odc_corr_if.eng corr
);
  localparam int CYC = CORR_CYCLES;

  // below two the next pass could start back to back; above 300 the duration check cannot follow
  if (CORR_CYCLES < 2 || CORR_CYCLES > 300) begin : g_bad_cycles
    $error("odc_corr_engine: CORR_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // code * (0.5 + gain/65536) + signed offset, clamped to 0..ffff
  function automatic odc_pkg::odc_word_t correct(input odc_pkg::odc_word_t code,
                                                 input odc_pkg::odc_word_t gain,
                                                 input odc_pkg::odc_word_t offset);
    logic [32:0] prod;
    logic signed [18:0] sum;
    prod = code * (`ODC_GAIN_BASE + {1'b0, gain});
    sum = $signed({2'b00, prod[32:16]}) + $signed({{3{offset[15]}}, offset});
    if (sum < 0) begin
      correct = 16'h0000;
    end else if (sum > $signed(19'h0ffff)) begin
      correct = 16'hffff;
    end else begin
      correct = sum[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  odc_pkg::odc_eng_state_e state_reg;
  logic [15:0] cnt_reg;
  odc_pkg::odc_chan_t chan_reg;
  odc_pkg::odc_word_t result_reg;

  // one channel per pass, fixed duration
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= odc_pkg::ODC_IDLE;
      cnt_reg <= 16'h0000;
    end else if (!i_enable) begin
      state_reg <= odc_pkg::ODC_IDLE;
      cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        odc_pkg::ODC_IDLE: begin
          if (corr.start) begin
            state_reg <= odc_pkg::ODC_RUN;
            cnt_reg <= 16'(CORR_CYCLES - 1);
          end
        end
        odc_pkg::ODC_RUN: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= odc_pkg::ODC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // operands are captured once, so later writes do not disturb a pass
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chan_reg <= 3'h0;
      result_reg <= 16'h0000;
    end else if (corr.start && state_reg == odc_pkg::ODC_IDLE) begin
      chan_reg <= corr.chan;
      result_reg <= correct(corr.code, corr.gain, corr.offset);
    end
  end

  assign corr.done = i_enable && state_reg == odc_pkg::ODC_RUN && cnt_reg == 16'h0000;
  assign corr.done_chan = chan_reg;
  assign corr.result = result_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pass_duration: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_enable)
    (corr.start && state_reg == odc_pkg::ODC_IDLE) |-> ##CYC corr.done)
    else $error("correction pass did not finish in time");
  a_unity_gain: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_enable)
    (corr.start && state_reg == odc_pkg::ODC_IDLE && corr.gain == 16'h8000 && corr.offset == 16'h0000)
    |=> (result_reg == $past(corr.code)))
    else $error("unity gain changed the code");
  c_one_pass: cover property (@(posedge i_mclk) disable iff (!i_rst_n) corr.done);
endmodule

// >>> sim/odc_pin_model.sv
module odc_pin_model (
  // device side of the open-drain pin
  input wire logic i_oe_n,
  input wire logic i_drive,
  // another board party pulling the line low
  input wire logic i_ext_low,
  // resolved line level
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-up gives the high level unless someone pulls the line low
  assign o_pin = ((!i_oe_n && !i_drive) || i_ext_low) ? 1'b0 : 1'b1;
endmodule

// >>> sim/tb.sv
`include "odc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CC = 4;
  logic i_mclk, i_rst_n, cs, we, re, en, ext_low, rvalid, mon_oe_n, aux, aux_oe_n, pin;
  logic [4:0] addr;
  logic [15:0] wd, rdata, d, c, g, z;
  logic [2:0] ch;
  logic [127:0] chb;
  logic [7:0] upd;
  logic [11:0] msel;
  logic [31:0] seed = 32'ha1eb;
  logic [47:0] corner [4] = '{48'hffff_ffff_0000, 48'h0001_0000_8000, 48'h8000_8000_0000, 48'h1234_0000_7fff};
  int n_fail = 0, num_checks = 0, cyc = 0;
  odc_regs #(.CHANNELS(8), .CORR_CYCLES(CC)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus_cs(cs),
    .i_bus_we(we), .i_bus_re(re), .i_bus_addr(addr), .i_bus_wdata(wd), .o_bus_rdata(rdata),
    .o_bus_rvalid(rvalid), .i_correction_enable(en), .o_channel_code_bits(chb), .o_channel_updated(upd),
    .o_analog_monitor_sel(msel), .o_analog_monitor_oe_n(mon_oe_n), .i_aux_pin(pin), .o_aux_pin(aux),
    .o_aux_pin_oe_n(aux_oe_n));
  odc_pin_model pm (.i_oe_n(aux_oe_n), .i_drive(aux), .i_ext_low(ext_low), .o_pin(pin));
  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // cut a hang short
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // code times gain coefficient plus signed offset, clamped
  function automatic logic [15:0] exp_corr(input logic [15:0] ci, gi, zi);
    longint v;
    v = ((longint'(ci) * (longint'(gi) + 32768)) >>> 16) + longint'(signed'(zi));
    if (v < 0) return 16'h0000;
    if (v > 65535) return 16'hffff;
    return v[15:0];
  endfunction
  task automatic chkw(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask
  // bus cycles: request held until the taking edge, strobes left up
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    cs = 1;
    we = 1;
    re = 0;
    addr = a;
    wd = v;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    cs = 1;
    we = 0;
    re = 1;
    addr = a;
    @(posedge i_mclk);
    #1;
    chkb(rvalid, 1'b1);
    d = rdata;
    chkw(d, e);
  endtask
  task automatic tick(input int n);
    cs = 0;
    we = 0;
    re = 0;
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wait_idle;
    // room for a stale pass and its repeat
    tick(3 * (CC + 2));
    rdc(`ODC_OFS_BUSY, 16'h0000);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst_n = 0;
    {cs, we, re, en, ext_low, addr, wd} = '0;
    repeat (8) @(posedge i_mclk);
    #1 i_rst_n = 1;
    chkb(mon_oe_n, 1'b1);
    chkb(aux_oe_n, 1'b1);
    tick(4);
    rdc(`ODC_OFS_MONITOR, 16'h0000);
    rdc(`ODC_OFS_AUX_PIN, 16'h8000);
    rdc(`ODC_OFS_BUSY, 16'h0000);
    rdc(5'h0f, 16'h0000);
    rdc(5'h13, 16'h0000);
    rdc(5'h1e, 16'h8000);
    rdc(5'h05, 16'h0000);
    // every legal monitor route, low bits written as ones
    for (int k = 0; k < 12; k++) begin
      wr(`ODC_OFS_MONITOR, (16'h0010 << k) | 16'h000f);
      chkw({4'h0, msel}, 16'h0001 << k);
      chkb(mon_oe_n, 1'b0);
      rdc(`ODC_OFS_MONITOR, 16'h0010 << k);
    end
    seed = lfsr(seed);
    wr(`ODC_OFS_MONITOR, seed[15:0] | 16'h0030);
    chkb(mon_oe_n, 1'b1);
    rdc(`ODC_OFS_MONITOR, (seed[15:0] | 16'h0030) & 16'hfff0);
    // aux pin driven low, released, then pulled low from outside
    wr(`ODC_OFS_AUX_PIN, 16'h7fff);
    chkb(aux_oe_n, 1'b0);
    chkb(aux, 1'b0);
    tick(5);
    rdc(`ODC_OFS_AUX_PIN, 16'h0000);
    wr(`ODC_OFS_AUX_PIN, 16'hffff);
    chkb(aux_oe_n, 1'b1);
    tick(5);
    rdc(`ODC_OFS_AUX_PIN, 16'h8000);
    ext_low = 1;
    tick(5);
    rdc(`ODC_OFS_AUX_PIN, 16'h0000);
    ext_low = 0;
    wr(`ODC_OFS_BUSY, 16'hffff);
    rdc(`ODC_OFS_BUSY, 16'h0000);
    // correction off: codes go straight through
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr({`ODC_BANK_CODE, 3'(i)}, seed[15:0]);
      chkw(chb[16*i +: 16], seed[15:0]);
      chkb(upd[i], 1'b1);
      rdc(`ODC_OFS_BUSY, 16'h0000);
    end
    // correction on: corners then random operands
    en = 1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ch = seed[2:0];
      {c, g, z} = (i < 4) ? corner[i] : {seed, seed[23:8]};
      wr({`ODC_BANK_ZERO, ch}, z);
      wr({`ODC_BANK_GAIN, ch}, g);
      wr({`ODC_BANK_CODE, ch}, c);
      rdc(`ODC_OFS_BUSY, 16'h0100 << ch);
      wait_idle();
      chkw(chb[16*ch +: 16], exp_corr(c, g, z));
    end
    // two pending channels run one after the other
    wr(5'h09, 16'h1111);
    wr(5'h0e, 16'h2222);
    rdc(`ODC_OFS_BUSY, 16'h4200);
    for (int i = 0; i < 20 && upd[1] !== 1'b1; i++) tick(1);
    chkb(upd[1], 1'b1);
    rdc(`ODC_OFS_BUSY, 16'h4000);
    wait_idle();
    // engine switched off with work pending
    wr(5'h0b, 16'h3333);
    en = 0;
    tick(1);
    rdc(`ODC_OFS_BUSY, 16'h0000);
    conclude();
  end
endmodule
